//--- eac_nv_model.sv
`timescale 1ns/1ns
`default_nettype none

module eac_nv_model (
  // clock
  input wire logic sys_clk,
  // array request
  input wire logic [11:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_rd_en,
  input wire logic nv_erase_en,
  input wire logic nv_write_en,
  // array answer
  output logic [7:0] nv_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] last_q = 8'h00;
  logic act_q = 1'b0;

  // known fill pattern so unwritten bytes still give checkable data
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
  end

  // released bus shows the inverse of the last byte, never a stale copy
  assign nv_rdata = nv_rd_en ? mem[nv_addr] : ~last_q;

  // erase sets all ones, write can only clear bits
  always @(posedge sys_clk) begin
    if (nv_rd_en) begin
      last_q <= mem[nv_addr];
    end
    act_q <= nv_erase_en | nv_write_en;
    if ((nv_erase_en | nv_write_en) && !act_q) begin
      mem[nv_addr] <= (nv_erase_en ? 8'hff : mem[nv_addr]) &
                      (nv_write_en ? nv_wdata : 8'hff);
    end
  end
endmodule

`default_nettype wire

//--- eac_params.svh
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

// i/o register offsets
`define EAC_OFS_CTRL 6'h1f
`define EAC_OFS_DATA 6'h20
`define EAC_OFS_ADDR_LO 6'h21
`define EAC_OFS_ADDR_HI 6'h22

// control register field positions
`define EAC_BIT_READ 0
`define EAC_BIT_PROG 1
`define EAC_BIT_MASTER 2
`define EAC_BIT_RIE 3
`define EAC_MODE_LSB 4
`define EAC_MODE_MSB 5
`define EAC_RSVD_LSB 6
`define EAC_RSVD_MSB 7

// reset values
`define EAC_MODE_RESET 2'h0
`define EAC_BYTE_ZERO 8'h00

// timing counts
`define EAC_MASTER_WINDOW 3'h4
`define EAC_STALL_PROG 3'h2
`define EAC_STALL_READ 3'h4
`define EAC_ATOMIC_RC_CYCLES 26368
`define EAC_ATOMIC_TIME_US 3400
`define EAC_SPLIT_TIME_US 1800
`define EAC_RC_DIV 3

// array geometry
`define EAC_ADDR_BITS 12

`endif

//--- eac_pkg.sv
package eac_pkg;

  // programming action chosen by the mode field, in field encoding order
  typedef enum logic [1:0] {
    EAC_MODE_ATOMIC,
    EAC_MODE_ERASE,
    EAC_MODE_WRITE,
    EAC_MODE_RSVD
  } eac_mode_t;

  // programming timer state
  typedef enum logic {
    EAC_TMR_IDLE,
    EAC_TMR_RUN
  } eac_tmr_state_t;

endpackage

//--- eac_prog_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "eac_params.svh"

module eac_prog_timer
  import eac_pkg::*;
#(
  parameter int CNT_W = 15,
  parameter int RC_DIV = `EAC_RC_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // start request with length in oscillator ticks
  input wire logic load,
  input wire logic [CNT_W-1:0] load_ticks,
  // one-cycle end of programming
  output logic done_q
);

  eac_tmr_state_t state_q;
  eac_tmr_state_t state_d;
  logic [CNT_W-1:0] ticks_q;
  logic [CNT_W-1:0] ticks_d;
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic done_d;
  logic tick;

  // divider stands in for the calibrated rc oscillator; it restarts on load
  // so every operation sees whole oscillator periods
  assign tick = (state_q == EAC_TMR_RUN) && (div_q == 8'(RC_DIV - 1));

  always_comb begin
    state_d = state_q;
    ticks_d = ticks_q;
    div_d = div_q;
    done_d = 1'b0;
    case (state_q)
      EAC_TMR_IDLE: begin
        div_d = 8'h00;
        if (load) begin
          ticks_d = load_ticks;
          state_d = EAC_TMR_RUN;
        end
      end
      EAC_TMR_RUN: begin
        div_d = tick ? 8'h00 : div_q + 8'h01;
        if (tick) begin
          ticks_d = ticks_q - 1'b1;
          if (ticks_q == CNT_W'(1)) begin
            done_d = 1'b1;
            state_d = EAC_TMR_IDLE;
          end
        end
      end
      default: begin
        state_d = EAC_TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= EAC_TMR_IDLE;
      ticks_q <= '0;
      div_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ticks_q <= ticks_d;
      div_q <= div_d;
      done_q <= done_d;
    end
  end

endmodule
`default_nettype wire

//--- eac_stall.sv
`timescale 1ns/1ns
`default_nettype none
`include "eac_params.svh"

module eac_stall #(
  parameter int CNT_W = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // load request
  input wire logic load,
  input wire logic [CNT_W-1:0] load_cycles,
  // stall level
  output logic stall_q
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic stall_d;

  // stall stands for exactly load_cycles cycles after the load edge
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_cycles;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
    stall_d = (cnt_d != '0);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      stall_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      stall_q <= stall_d;
    end
  end

endmodule
`default_nettype wire

//--- eac_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "eac_params.svh"

module eac_top
  import eac_pkg::*;
#(
  parameter int ADDR_W = `EAC_ADDR_BITS,
  parameter int RC_DIV = `EAC_RC_DIV,
  parameter int ATOMIC_TICKS = `EAC_ATOMIC_RC_CYCLES,
  parameter int SPLIT_TICKS = `EAC_ATOMIC_RC_CYCLES * `EAC_SPLIT_TIME_US / `EAC_ATOMIC_TIME_US
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cpu_rst,
  // i/o register port
  input wire logic [5:0] io_addr,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // cpu side status
  input wire logic global_irq_enable,
  input wire logic flash_selfprog_enable,
  output logic ready_irq,
  output logic cpu_stall,
  // nonvolatile array
  output logic [ADDR_W-1:0] nv_addr,
  output logic [7:0] nv_wdata,
  output logic nv_rd_en,
  output logic nv_erase_en,
  output logic nv_write_en,
  input wire logic [7:0] nv_rdata
);

  localparam int CNT_W = 15;

  eac_mode_t mode_q;
  eac_mode_t mode_d;
  logic rie_q;
  logic rie_d;
  logic busy_q;
  logic busy_d;
  logic [2:0] master_q;
  logic [2:0] master_d;
  logic master_active;
  logic ctrl_wr;
  logic start;
  logic rd_req;
  logic tmr_done;
  logic [CNT_W-1:0] tmr_ticks;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [7:0] rdata_d;
  logic irq_d;
  logic rd_en_d;
  logic erase_d;
  logic write_d;
  logic [7:0] addr_hi_rd;

  assign ctrl_wr = io_we && (io_addr == `EAC_OFS_CTRL);
  assign master_active = (master_q != 3'h0);

  // control register: mode, interrupt enable, master window, busy strobe
  always_comb begin
    mode_d = mode_q;
    rie_d = rie_q;
    busy_d = busy_q;
    master_d = master_active ? master_q - 3'h1 : master_q;
    start = 1'b0;
    rd_req = 1'b0;
    if (cpu_rst) begin
      rie_d = 1'b0;
      master_d = 3'h0;
      if (!busy_q) begin
        mode_d = eac_mode_t'(`EAC_MODE_RESET);
      end
    end else if (ctrl_wr) begin
      rie_d = io_wdata[`EAC_BIT_RIE];
      if (!busy_q) begin
        mode_d = eac_mode_t'(io_wdata[`EAC_MODE_MSB:`EAC_MODE_LSB]);
      end
      // a read-modify-write of the strobe rewrites master as one; that must
      // not reopen the window, or the timeout would never bite
      if (!io_wdata[`EAC_BIT_MASTER]) begin
        master_d = 3'h0;
      end else if (!master_active) begin
        master_d = `EAC_MASTER_WINDOW;
      end
      // reserved mode starts nothing; flash self-programming blocks start
      if (io_wdata[`EAC_BIT_PROG] && master_active && !busy_q && !flash_selfprog_enable &&
          mode_d != EAC_MODE_RSVD) begin
        start = 1'b1;
        busy_d = 1'b1;
        master_d = 3'h0;
      end else if (io_wdata[`EAC_BIT_READ] && !busy_q) begin
        rd_req = 1'b1;
      end
    end
    if (tmr_done) begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= EAC_MODE_ATOMIC;
      rie_q <= 1'b0;
      busy_q <= 1'b0;
      master_q <= 3'h0;
    end else begin
      mode_q <= mode_d;
      rie_q <= rie_d;
      busy_q <= busy_d;
      master_q <= master_d;
    end
  end

  // atomic takes the full length, the split actions the shorter one
  assign tmr_ticks = (mode_d == EAC_MODE_ATOMIC) ? CNT_W'(ATOMIC_TICKS) : CNT_W'(SPLIT_TICKS);

  // programming length counted in oscillator ticks
  eac_prog_timer #(
    .CNT_W(CNT_W),
    .RC_DIV(RC_DIV)
  ) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(start),
    .load_ticks(tmr_ticks),
    .done_q(tmr_done)
  );

  // cpu halt after a programming start or a read
  eac_stall #(
    .CNT_W(3)
  ) u_stall (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(start || rd_req),
    .load_cycles(start ? `EAC_STALL_PROG : `EAC_STALL_READ),
    .stall_q(cpu_stall)
  );

  // address and data registers
  always_comb begin
    addr_d = addr_q;
    data_d = data_q;
    if (io_we && !busy_q) begin
      if (io_addr == `EAC_OFS_ADDR_LO) begin
        addr_d[7:0] = io_wdata;
      end else if (io_addr == `EAC_OFS_ADDR_HI) begin
        addr_d[ADDR_W-1:8] = io_wdata[ADDR_W-9:0];
      end
    end
    if (io_we && io_addr == `EAC_OFS_DATA) begin
      data_d = io_wdata;
    end
    // fetched byte wins over a same-cycle data write: the cpu is stalled
    if (nv_rd_en) begin
      data_d = nv_rdata;
    end
  end

  // the address has no reset value; zero keeps simulation free of unknowns
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= '0;
      data_q <= `EAC_BYTE_ZERO;
    end else begin
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign addr_hi_rd = 8'(addr_q[ADDR_W-1:8]);

  // read mux and registered outputs
  always_comb begin
    rdata_d = `EAC_BYTE_ZERO;
    if (io_re) begin
      case (io_addr)
        `EAC_OFS_CTRL: begin
          rdata_d[`EAC_MODE_MSB:`EAC_MODE_LSB] = mode_q;
          rdata_d[`EAC_BIT_RIE] = rie_q;
          rdata_d[`EAC_BIT_MASTER] = master_active;
          rdata_d[`EAC_BIT_PROG] = busy_q;
          rdata_d[`EAC_RSVD_MSB:`EAC_RSVD_LSB] = 2'h0;
        end
        `EAC_OFS_DATA: begin
          rdata_d = data_q;
        end
        `EAC_OFS_ADDR_LO: begin
          rdata_d = addr_q[7:0];
        end
        `EAC_OFS_ADDR_HI: begin
          rdata_d = addr_hi_rd;
        end
        default: begin
          rdata_d = `EAC_BYTE_ZERO;
        end
      endcase
    end
    irq_d = rie_q && global_irq_enable && !busy_q;
    rd_en_d = rd_req;
    erase_d = busy_d && (mode_d != EAC_MODE_WRITE);
    write_d = busy_d && (mode_d != EAC_MODE_ERASE);
  end

  // array strobes stand through the whole operation; data is latched at start
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= `EAC_BYTE_ZERO;
      ready_irq <= 1'b0;
      nv_rd_en <= 1'b0;
      nv_erase_en <= 1'b0;
      nv_write_en <= 1'b0;
      nv_addr <= '0;
      nv_wdata <= `EAC_BYTE_ZERO;
    end else begin
      io_rdata <= rdata_d;
      ready_irq <= irq_d;
      nv_rd_en <= rd_en_d;
      nv_erase_en <= erase_d;
      nv_write_en <= write_d;
      nv_addr <= addr_d;
      if (start) begin
        nv_wdata <= data_d;
      end
    end
  end

  // checks on the control logic
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  AST_RSVD_ZERO: assert property (
    io_re && io_addr == `EAC_OFS_CTRL |=> io_rdata[7:6] == 2'h0)
    else $error("reserved control bits read nonzero");

  AST_MODE_LOCK: assert property (
    busy_q |=> mode_q == $past(mode_q))
    else $error("mode changed while programming");

  AST_RESET_MODE: assert property (
    cpu_rst && !busy_q |=> mode_q == EAC_MODE_ATOMIC && !rie_q)
    else $error("reset did not clear mode");

  AST_READY_IRQ: assert property (
    rie_q && global_irq_enable && !busy_q |=> ready_irq)
    else $error("ready interrupt missing");

  AST_NO_STRAY_START: assert property (
    ctrl_wr && io_wdata[`EAC_BIT_PROG] && !master_active && !busy_q |=> !busy_q)
    else $error("start without master enable");

  AST_MASTER_TIMEOUT: assert property (
    ctrl_wr && io_wdata[`EAC_BIT_MASTER] && !master_active && !cpu_rst
    |=> master_active ##4 !master_active)
    else $error("master enable window not four cycles");

  AST_FLASH_BLOCK: assert property (
    $rose(busy_q) |-> !$past(flash_selfprog_enable))
    else $error("start during flash write");

  AST_DONE_CLEARS: assert property (
    tmr_done |=> !busy_q && !nv_write_en && !nv_erase_en)
    else $error("strobe not cleared at end");

  AST_PROG_STALL: assert property (
    $rose(busy_q) |-> cpu_stall [*2] ##1 !cpu_stall)
    else $error("program stall not two cycles");

  AST_READ_STALL: assert property (
    nv_rd_en |-> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");

  AST_READ_CAPTURE: assert property (
    nv_rd_en |=> data_q == $past(nv_rdata))
    else $error("read byte not captured");

  AST_BUSY_FREEZE: assert property (
    busy_q |=> !nv_rd_en && addr_q == $past(addr_q))
    else $error("read or address change while busy");

  AST_BUSY_READBACK: assert property (
    io_re && io_addr == `EAC_OFS_CTRL |=> io_rdata[`EAC_BIT_PROG] == $past(busy_q))
    else $error("strobe readback differs from busy");

  COV_PROG: cover property ($rose(busy_q) ##[1:1000] !busy_q);
  COV_READ: cover property (nv_rd_en ##1 !cpu_stall [*1]);
  COV_TIMEOUT: cover property ($fell(master_active) && !busy_q);
  COV_SPLIT: cover property ($rose(busy_q) && mode_q == EAC_MODE_ERASE);

endmodule
`default_nettype wire

//--- eeprom_access_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "eac_params.svh"

module eeprom_access_control_tb_top;
  logic sys_clk, rstn, cpu_rst, io_we, io_re, gie, flash, ready_irq, cpu_stall;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata, nv_wdata, nv_rdata, v, d;
  logic [11:0] nv_addr, a;
  logic nv_rd_en, nv_erase_en, nv_write_en, rie;
  logic [31:0] rnd;
  int failures, compares, stalls, stall_base;
  int mem_m [int];

  eac_top #(.ATOMIC_TICKS(20), .SPLIT_TICKS(10)) eac_top_i (
    .sys_clk(sys_clk), .rstn(rstn), .cpu_rst(cpu_rst),
    .io_addr(io_addr), .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .global_irq_enable(gie), .flash_selfprog_enable(flash),
    .ready_irq(ready_irq), .cpu_stall(cpu_stall), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_rd_en(nv_rd_en), .nv_erase_en(nv_erase_en),
    .nv_write_en(nv_write_en), .nv_rdata(nv_rdata)
  );

  eac_nv_model eac_nv_model_i (
    .sys_clk(sys_clk), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rd_en(nv_rd_en),
    .nv_erase_en(nv_erase_en), .nv_write_en(nv_write_en), .nv_rdata(nv_rdata)
  );

  // clock and stall-cycle counter
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cpu_stall === 1'b1) stalls++;

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // array contents as the bench expects them
  function logic [7:0] mget(input int x);
    if (mem_m.exists(x)) return mem_m[x][7:0];
    return x[7:0] ^ 8'h5a;
  endfunction

  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task wr(input logic [5:0] ad, input logic [7:0] wd);
    @(posedge sys_clk);
    io_addr <= ad;
    io_wdata <= wd;
    io_we <= 1'b1;
    @(posedge sys_clk);
    io_we <= 1'b0;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task rd(input logic [5:0] ad);
    @(posedge sys_clk);
    io_addr <= ad;
    io_re <= 1'b1;
    @(posedge sys_clk);
    io_re <= 1'b0;
    #1 v = io_rdata;
  endtask

  // master enable first, strobe after late extra cycles
  task prog(input logic [1:0] m, input int late);
    a = rnd[11:0];
    d = rnd[19:12];
    rnd = lfsr(rnd);
    wr(`EAC_OFS_ADDR_LO, a[7:0]);
    // upper bits written as ones must still read back as zero
    wr(`EAC_OFS_ADDR_HI, {4'hf, a[11:8]});
    wr(`EAC_OFS_DATA, d);
    wr(`EAC_OFS_CTRL, {2'h0, m, rie, 3'h4});
    repeat (late) @(posedge sys_clk);
    stall_base = stalls;
    wr(`EAC_OFS_CTRL, {2'h0, m, rie, 3'h6});
  endtask

  // poll the busy bit under a bound
  task wait_idle;
    for (int i = 0; i < 300; i++) begin
      rd(`EAC_OFS_CTRL);
      if (v[1] === 1'b0) break;
    end
    if (v[1] !== 1'b0) failures++;
  endtask

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    cpu_rst = 1'b0;
    io_addr = 6'h00;
    io_we = 1'b0;
    io_re = 1'b0;
    io_wdata = 8'h00;
    gie = 1'b0;
    flash = 1'b0;
    rie = 1'b0;
    rnd = 32'h84e9;
    failures = 0;
    compares = 0;
    stall_base = 0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(`EAC_OFS_CTRL);
    chk(v, 8'h00);
    wr(`EAC_OFS_CTRL, 8'hff);
    rd(`EAC_OFS_CTRL);
    chk(v, 8'h3c);
    repeat (4) @(posedge sys_clk);
    rd(`EAC_OFS_CTRL);
    chk(v, 8'h38);
    rie = 1'b1;
    @(posedge sys_clk) gie <= 1'b1;
    wr(`EAC_OFS_CTRL, 8'h08);
    repeat (3) @(posedge sys_clk);
    #1 chk({7'h0, ready_irq}, 8'h01);
    // every defined mode, with refused writes while busy
    for (int m = 0; m < 3; m++) begin
      prog(m[1:0], 0);
      rd(`EAC_OFS_CTRL);
      chk(v, {2'h0, m[1:0], 4'ha});
      chk({7'h0, ready_irq}, 8'h00);
      wr(`EAC_OFS_ADDR_LO, ~a[7:0]);
      wr(`EAC_OFS_CTRL, 8'h38);
      wait_idle;
      chk(v, {2'h0, m[1:0], 4'h8});
      chk(8'(stalls - stall_base), 8'h02);
      mem_m[a] = (m == 1) ? 8'hff : (m == 2) ? (mget(a) & d) : d;
      stall_base = stalls;
      wr(`EAC_OFS_CTRL, 8'h09);
      repeat (6) @(posedge sys_clk);
      rd(`EAC_OFS_DATA);
      chk(v, mget(a));
      chk(8'(stalls - stall_base), 8'h04);
      rd(`EAC_OFS_ADDR_LO);
      chk(v, a[7:0]);
      rd(`EAC_OFS_ADDR_HI);
      chk(v, {4'h0, a[11:8]});
    end
    // a late strobe, as after an interrupt, starts nothing; its master bit
    // opens a fresh window, which still reads one
    prog(2'h0, 4);
    rd(`EAC_OFS_CTRL);
    chk(v, 8'h0c);
    @(posedge sys_clk) flash <= 1'b1;
    prog(2'h0, 0);
    rd(`EAC_OFS_CTRL);
    chk(v, 8'h0c);
    @(posedge sys_clk) flash <= 1'b0;
    prog(2'h3, 0);
    rd(`EAC_OFS_CTRL);
    chk(v, 8'h3c);
    // system reset in mid-erase keeps the mode, then clears it when idle
    rie = 1'b0;
    prog(2'h1, 0);
    @(posedge sys_clk) cpu_rst <= 1'b1;
    @(posedge sys_clk) cpu_rst <= 1'b0;
    wait_idle;
    chk(v, 8'h10);
    @(posedge sys_clk) cpu_rst <= 1'b1;
    @(posedge sys_clk) cpu_rst <= 1'b0;
    rd(`EAC_OFS_CTRL);
    chk(v, 8'h00);
    close_out;
  end

  // hang guard, about thirty times the expected run
  initial begin
    #400000;
    failures++;
    close_out;
  end
endmodule

`default_nettype wire
